/* design/flash_burst_pkg.sv */
package flash_burst_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int CFG_W = 16;
    localparam int BANK_BIT = ADDR_W - 1;

    // ------------------------------------------------------------------
    // Read-configuration register layout and reset value
    // ------------------------------------------------------------------
    localparam logic [CFG_W-1:0] CFG_RESET = 16'h9CC4;
    localparam int RM_BIT = 15;
    localparam int ASD_BIT = 14;
    localparam int IAD_LSB = 10;
    localparam int IAD_MSB = 13;
    localparam int DOC_BIT = 9;
    localparam int WC_BIT = 8;
    localparam int BS_BIT = 7;
    localparam int CC_BIT = 6;
    localparam int RSV_MSB = 5;
    localparam int RSV_LSB = 3;
    localparam int BL_MSB = 2;
    localparam int BL_LSB = 0;

    // ------------------------------------------------------------------
    // Burst-length codes and delay decode
    // ------------------------------------------------------------------
    localparam logic [2:0] BL_TWO = 3'h1;
    localparam logic [2:0] BL_FOUR = 3'h2;
    localparam logic [2:0] BL_EIGHT = 3'h3;
    localparam logic [3:0] DELAY_BASE = 4'h2;
    localparam logic [3:0] IAD_MAX_CODE = 4'h7;
    localparam logic [3:0] WAIT_LAST = 4'h1;

    // ------------------------------------------------------------------
    // Burst sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DATA = 2'b10
    } burst_state_t;

endpackage : flash_burst_pkg

/* design/flash_burst_read_config.sv */
`timescale 1ns/10ps
`default_nettype none

module flash_burst_read_config
    import flash_burst_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bus pins from the memory controller
    input wire logic address_valid_n,
    input wire logic chipEnableN,
    input wire logic outputEnableN,
    input wire logic [ADDR_W-1:0] addrIn,
    // Data and indicator pins
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe,
    output logic end_of_burst_indicator_n,
    output logic indicatorOe,
    // Command decoder side
    input wire logic cfgWriteStrobe,
    input wire logic [CFG_W-1:0] cfgWriteData,
    input wire logic cfgReadCmd,
    input wire logic cfgReadBank,
    input wire logic cfgReadExit,
    input wire logic programEraseBusy,
    // Array port
    output logic [ADDR_W-1:0] arrayAddr,
    input wire logic [DATA_W-1:0] arrayData,
    // Status
    output logic [CFG_W-1:0] read_config_reg,
    output logic automaticSleepAllowed
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic [3:0] delayOf(input logic [3:0] code);
        if (code > IAD_MAX_CODE)
            return IAD_MAX_CODE + DELAY_BASE;
        return code + DELAY_BASE;
    endfunction : delayOf

    function automatic logic [2:0] maskOf(input logic [2:0] code);
        case (code)
            BL_TWO: return 3'h1;
            BL_FOUR: return 3'h3;
            BL_EIGHT: return 3'h7;
            default: return 3'h0;
        endcase
    endfunction : maskOf

    // Reserved and fixed bits are forced; delay codes above 7 are still stored, and delayOf clamps them to 9 clocks.
    function automatic logic [CFG_W-1:0] sanitize(input logic [CFG_W-1:0] v);
        logic [CFG_W-1:0] s;
        s = v;
        s[CC_BIT] = 1'b1;
        s[DOC_BIT] = 1'b0;
        s[BS_BIT] = 1'b1;
        s[RSV_MSB:RSV_LSB] = 3'h0;
        return s;
    endfunction : sanitize

    function automatic logic [ADDR_W-1:0] nextInBlock(input logic [ADDR_W-1:0] a, input logic [2:0] m);
        logic [2:0] inc;
        inc = a[2:0] + 3'h1;
        return {a[ADDR_W-1:3], (a[2:0] & ~m) | (inc & m)};
    endfunction : nextInBlock

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    burst_state_t state_r;
    logic [CFG_W-1:0] cfg_r;
    logic cfgReadActive_r;
    logic cfgBank_r;
    logic advSeen_r;
    logic [3:0] waitCnt_r;
    logic [2:0] lenMask_r;
    logic [2:0] beatCnt_r;
    logic [ADDR_W-1:0] arrayAddr_r;
    logic [DATA_W-1:0] dataOut_r;
    logic indN_r;
    logic sleepOk_r;
    logic burstEnable;
    logic startBurst;
    logic loadBeat;
    logic firstBeat;
    logic [2:0] nextBeat;
    logic [2:0] indBeat;

    assign burstEnable = !cfg_r[RM_BIT] && (maskOf(cfg_r[BL_MSB:BL_LSB]) != 3'h0);
    // Register reads never start a burst, so they stay single-cycle.
    assign startBurst = !address_valid_n && !chipEnableN && !advSeen_r && burstEnable
        && !(cfgReadActive_r && addrIn[BANK_BIT] == cfgBank_r);
    assign firstBeat = (state_r == ST_WAIT) && (waitCnt_r == WAIT_LAST) && !startBurst;
    assign loadBeat = !chipEnableN && (firstBeat || ((state_r == ST_DATA) && !startBurst));
    assign nextBeat = firstBeat ? 3'h0 : ((beatCnt_r + 3'h1) & lenMask_r);
    assign indBeat = cfg_r[WC_BIT] ? (lenMask_r - 3'h1) : lenMask_r;

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_r <= CFG_RESET;
        else if (cfgWriteStrobe && !programEraseBusy)
            cfg_r <= sanitize(cfgWriteData);
    end

    // The set wins over the exit so a read command in the exit cycle is kept.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfgReadActive_r <= 1'b0;
            cfgBank_r <= 1'b0;
        end
        else if (cfgReadCmd)
        begin
            cfgReadActive_r <= 1'b1;
            cfgBank_r <= cfgReadBank;
        end
        else if (cfgReadExit)
            cfgReadActive_r <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Burst sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            advSeen_r <= 1'b0;
        else if (address_valid_n)
            advSeen_r <= 1'b0;
        else if (startBurst)
            advSeen_r <= 1'b1;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= ST_IDLE;
        else if (chipEnableN)
            state_r <= ST_IDLE;
        else if (startBurst)
            state_r <= ST_WAIT;
        else
        begin
            case (state_r)
                ST_IDLE: state_r <= ST_IDLE;
                ST_WAIT:
                begin
                    if (waitCnt_r == WAIT_LAST)
                        state_r <= ST_DATA;
                end
                ST_DATA: state_r <= ST_DATA;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // The first word is registered one edge before the delay expires, so it is valid on that edge.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitCnt_r <= 4'h0;
            lenMask_r <= 3'h0;
        end
        else if (startBurst)
        begin
            waitCnt_r <= delayOf(cfg_r[IAD_MSB:IAD_LSB]) - 4'h1;
            lenMask_r <= maskOf(cfg_r[BL_MSB:BL_LSB]);
        end
        else if (state_r == ST_WAIT && waitCnt_r != 4'h0)
            waitCnt_r <= waitCnt_r - 4'h1;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            beatCnt_r <= 3'h0;
        else if (loadBeat)
            beatCnt_r <= nextBeat;
    end

    // ------------------------------------------------------------------
    // Array addressing and data path
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            arrayAddr_r <= '0;
        else if (startBurst)
            arrayAddr_r <= addrIn;
        else if (state_r == ST_IDLE && !address_valid_n)
            arrayAddr_r <= addrIn;
        else if (loadBeat)
            arrayAddr_r <= nextInBlock(arrayAddr_r, lenMask_r);
    end

    // Each beat replaces the last on the next edge, giving a one-clock hold.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            dataOut_r <= '0;
        else if (loadBeat)
            dataOut_r <= arrayData;
        else if (state_r == ST_IDLE)
        begin
            if (cfgReadActive_r && arrayAddr_r[BANK_BIT] == cfgBank_r)
                dataOut_r <= {16'h0000, cfg_r};
            else
                dataOut_r <= arrayData;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            indN_r <= 1'b1;
        else
            indN_r <= !(loadBeat && nextBeat == indBeat);
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            sleepOk_r <= 1'b0;
        else
            sleepOk_r <= !cfg_r[ASD_BIT] && chipEnableN && state_r == ST_IDLE;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Output enable only gates the pins; the burst keeps running while the bus floats.
    assign dataOe = !chipEnableN && !outputEnableN;
    assign indicatorOe = !chipEnableN && !outputEnableN && state_r == ST_DATA;
    assign dataOut = dataOut_r;
    assign end_of_burst_indicator_n = indN_r;
    assign arrayAddr = arrayAddr_r;
    assign read_config_reg = cfg_r;
    assign automaticSleepAllowed = sleepOk_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [4:0] sinceCap_r;
    logic [3:0] codeCap_r;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sinceCap_r <= 5'h00;
            codeCap_r <= 4'h0;
        end
        else if (startBurst)
        begin
            sinceCap_r <= 5'h00;
            codeCap_r <= cfg_r[IAD_MSB:IAD_LSB];
        end
        else if (sinceCap_r != 5'h1F)
            sinceCap_r <= sinceCap_r + 5'h01;
    end

    property p_initialDelay;
        @(posedge ref_clk) disable iff (!rst_n)
        ($rose(state_r == ST_DATA) && codeCap_r <= IAD_MAX_CODE) |-> sinceCap_r == {1'b0, codeCap_r} + 5'h01;
    endproperty
    a_initialDelay: assert property (p_initialDelay) else $error("first burst word off its delay");

    property p_asyncStaysIdle;
        @(posedge ref_clk) disable iff (!rst_n)
        (cfg_r[RM_BIT] && state_r == ST_IDLE) |=> state_r == ST_IDLE;
    endproperty
    a_asyncStaysIdle: assert property (p_asyncStaysIdle) else $error("burst began in asynchronous mode");

    property p_capture;
        @(posedge ref_clk) disable iff (!rst_n)
        (!address_valid_n && !chipEnableN && !advSeen_r && burstEnable && !cfgReadActive_r)
            |=> (state_r == ST_WAIT && arrayAddr_r == $past(addrIn));
    endproperty
    a_capture: assert property (p_capture) else $error("address not captured at burst start");

    property p_busyWrite;
        @(posedge ref_clk) disable iff (!rst_n)
        (cfgWriteStrobe && programEraseBusy) |=> cfg_r == $past(cfg_r);
    endproperty
    a_busyWrite: assert property (p_busyWrite) else $error("register changed during program or erase");

    property p_cfgRead;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r == ST_IDLE && !loadBeat && cfgReadActive_r && arrayAddr_r[BANK_BIT] == cfgBank_r)
            |=> (dataOut[31:16] == 16'h0000 && dataOut[15:0] == $past(cfg_r));
    endproperty
    a_cfgRead: assert property (p_cfgRead) else $error("register read data wrong");

    property p_oneClockBeat;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r == ST_DATA && !chipEnableN && !startBurst)
            |=> (beatCnt_r == (($past(beatCnt_r) + 3'h1) & lenMask_r)
                && arrayAddr_r[ADDR_W-1:3] == $past(arrayAddr_r[ADDR_W-1:3]));
    endproperty
    a_oneClockBeat: assert property (p_oneClockBeat) else $error("beat not advanced within its block");

    property p_indicator;
        @(posedge ref_clk) disable iff (!rst_n)
        (!end_of_burst_indicator_n)
            |-> (state_r == ST_DATA && beatCnt_r == (cfg_r[WC_BIT] ? lenMask_r - 3'h1 : lenMask_r));
    endproperty
    a_indicator: assert property (p_indicator) else $error("indicator on wrong beat");

    property p_fixedBits;
        @(posedge ref_clk) disable iff (!rst_n)
        cfg_r[CC_BIT] && !cfg_r[DOC_BIT] && cfg_r[BS_BIT];
    endproperty
    a_fixedBits: assert property (p_fixedBits) else $error("fixed configuration bit changed");

    property p_ceExit;
        @(posedge ref_clk) disable iff (!rst_n)
        chipEnableN |=> state_r == ST_IDLE ##1 (state_r != ST_DATA);
    endproperty
    a_ceExit: assert property (p_ceExit) else $error("burst survived chip disable");

    property p_sleep;
        @(posedge ref_clk) disable iff (!rst_n)
        (cfg_r[ASD_BIT] && !cfgWriteStrobe) |=> !automaticSleepAllowed;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep allowed while disabled");

endmodule : flash_burst_read_config

`default_nettype wire

/* tb/flash_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module flash_host_model
    import flash_burst_pkg::*;
(
    // Clock from the bench
    input wire logic ref_clk,
    // Bus pins
    output logic address_valid_n,
    output logic chipEnableN,
    output logic outputEnableN,
    output logic [ADDR_W-1:0] addrIn,
    // Command decoder side
    output logic cfgWriteStrobe,
    output logic [CFG_W-1:0] cfgWriteData,
    output logic cfgReadCmd,
    output logic cfgReadBank,
    output logic cfgReadExit
);
    initial
    begin
        address_valid_n = 1'b1;
        chipEnableN = 1'b1;
        outputEnableN = 1'b1;
        addrIn = '0;
        cfgWriteStrobe = 1'b0;
        cfgWriteData = '0;
        cfgReadCmd = 1'b0;
        cfgReadBank = 1'b0;
        cfgReadExit = 1'b0;
    end

    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    // The address is inverted once released, so a stale value cannot pass for a held one.
    task automatic addrPhase(input logic [ADDR_W-1:0] a);
        @(negedge ref_clk);
        addrIn = a;
        address_valid_n = 1'b0;
        @(negedge ref_clk);
        address_valid_n = 1'b1;
        addrIn = ~a;
    endtask : addrPhase

    task automatic pins(input logic ce, input logic oe);
        @(negedge ref_clk);
        chipEnableN = ce;
        outputEnableN = oe;
    endtask : pins

    // The register is written, and its read mode entered and left, by these command pulses; its read data comes from an address in the chosen bank.
    task automatic command(input logic wr, input logic rd, input logic ex, input logic bank,
                           input logic [CFG_W-1:0] v);
        @(negedge ref_clk);
        cfgWriteStrobe = wr;
        cfgReadCmd = rd;
        cfgReadExit = ex;
        cfgReadBank = bank;
        cfgWriteData = v;
        @(negedge ref_clk);
        cfgWriteStrobe = 1'b0;
        cfgReadCmd = 1'b0;
        cfgReadExit = 1'b0;
        cfgWriteData = ~v;
    endtask : command
endmodule : flash_host_model

`default_nettype wire

/* tb/flash_burst_read_config_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module flash_burst_read_config_bench
    import flash_burst_pkg::*;
();
    logic ref_clk, rst_n, programEraseBusy, address_valid_n, chipEnableN, outputEnableN;
    logic cfgWriteStrobe, cfgReadCmd, cfgReadBank, cfgReadExit, dataOe, end_of_burst_indicator_n;
    logic indicatorOe, automaticSleepAllowed;
    logic [ADDR_W-1:0] addrIn, arrayAddr;
    logic [DATA_W-1:0] dataOut, arrayData;
    logic [CFG_W-1:0] cfgWriteData, read_config_reg;
    int numErrors = 0;
    int totalChecks = 0;
    int cycles = 0;

    // The array word carries its own address so misordered beats show up.
    function automatic logic [DATA_W-1:0] arr(input logic [ADDR_W-1:0] a);
        return {12'hA5A, a};
    endfunction : arr

    assign arrayData = arr(arrayAddr);

    flash_host_model host (.ref_clk(ref_clk), .address_valid_n(address_valid_n), .chipEnableN(chipEnableN),
        .outputEnableN(outputEnableN), .addrIn(addrIn), .cfgWriteStrobe(cfgWriteStrobe),
        .cfgWriteData(cfgWriteData), .cfgReadCmd(cfgReadCmd), .cfgReadBank(cfgReadBank),
        .cfgReadExit(cfgReadExit));

    flash_burst_read_config dut (.ref_clk(ref_clk), .rst_n(rst_n), .address_valid_n(address_valid_n),
        .chipEnableN(chipEnableN), .outputEnableN(outputEnableN), .addrIn(addrIn), .dataOut(dataOut),
        .dataOe(dataOe), .end_of_burst_indicator_n(end_of_burst_indicator_n), .indicatorOe(indicatorOe),
        .cfgWriteStrobe(cfgWriteStrobe), .cfgWriteData(cfgWriteData), .cfgReadCmd(cfgReadCmd),
        .cfgReadBank(cfgReadBank), .cfgReadExit(cfgReadExit), .programEraseBusy(programEraseBusy),
        .arrayAddr(arrayAddr), .arrayData(arrayData), .read_config_reg(read_config_reg),
        .automaticSleepAllowed(automaticSleepAllowed));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic checkWord(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            numErrors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : checkWord

    task automatic checkBit(input logic got, input logic exp);
        totalChecks++;
        if (got !== exp)
        begin
            numErrors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : checkBit

    task automatic testDone();
        if (numErrors == 0 && totalChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : testDone

    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            numErrors++;
            testDone();
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic readCheck(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        host.addrPhase(a);
        @(negedge ref_clk);
        checkWord(dataOut, exp);
    endtask : readCheck

    // Runs two passes of the block so the wrap and the indicator are seen twice.
    task automatic burst(input int lc, input int dc);
        int n, d;
        logic ind;
        logic [ADDR_W-1:0] a, w;
        n = 1 << lc;
        d = (dc > 7) ? 9 : dc + 2;
        ind = dc[0];
        a = 20'h0ABC5;
        host.command(1'b1, 1'b0, 1'b0, 1'b0, {2'b00, 4'(dc), 1'b0, ind, 2'b11, 3'b000, 3'(lc)});
        host.addrPhase(a);
        for (int j = 1; j < d; j++)
        begin
            if (j == d - 1) checkBit(indicatorOe, 1'b0);
            @(negedge ref_clk);
        end
        for (int k = 0; k < 2 * n; k++)
        begin
            w = (a & ~ADDR_W'(n - 1)) | ((a + ADDR_W'(k)) & ADDR_W'(n - 1));
            checkWord(dataOut, arr(w));
            checkBit(end_of_burst_indicator_n, (k % n) != (ind ? n - 2 : n - 1));
            checkBit(indicatorOe, 1'b1);
            @(negedge ref_clk);
        end
    endtask : burst

    initial
    begin
        rst_n = 1'b0;
        programEraseBusy = 1'b0;
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        checkWord({16'h0000, read_config_reg}, 32'h00009CC4);
        host.pins(1'b0, 1'b0);
        readCheck(20'h00123, arr(20'h00123));
        host.command(1'b1, 1'b0, 1'b0, 1'b0, 16'h463A);
        checkWord({16'h0000, read_config_reg}, 32'h000044C2);
        host.command(1'b1, 1'b0, 1'b0, 1'b0, 16'hC4C1);
        host.pins(1'b1, 1'b0);
        repeat (2) @(negedge ref_clk);
        checkBit(automaticSleepAllowed, 1'b0);
        host.pins(1'b0, 1'b0);
        readCheck(20'h00456, arr(20'h00456));
        host.command(1'b1, 1'b0, 1'b0, 1'b0, 16'h04C7);
        readCheck(20'h00789, arr(20'h00789));
        programEraseBusy = 1'b1;
        host.command(1'b1, 1'b0, 1'b0, 1'b0, 16'h9CC4);
        checkWord({16'h0000, read_config_reg}, 32'h000004C7);
        programEraseBusy = 1'b0;
        host.command(1'b0, 1'b1, 1'b0, 1'b1, 16'h0000);
        readCheck(20'h80010, 32'h000004C7);
        repeat (4) @(negedge ref_clk);
        checkWord(dataOut, 32'h000004C7);
        readCheck(20'h00010, arr(20'h00010));
        // With bursts enabled, a read in the register bank must still be a plain single-cycle read.
        host.command(1'b1, 1'b0, 1'b0, 1'b0, 16'h1CC3);
        readCheck(20'h80020, 32'h00001CC3);
        repeat (12) @(negedge ref_clk);
        checkWord(dataOut, 32'h00001CC3);
        host.command(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000);
        for (int lc = 1; lc <= 3; lc++)
        begin
            for (int i = 0; i < 3; i++)
            begin
                burst(lc, (i == 0) ? 0 : ((i == 1) ? 7 : 15));
                host.pins(1'b1, 1'b0);
                repeat (2) @(negedge ref_clk);
                checkBit(automaticSleepAllowed, 1'b1);
                checkBit(dataOe, 1'b0);
                host.pins(1'b0, 1'b0);
            end
        end
        host.addrPhase(20'h0ABC5);
        repeat (10) @(negedge ref_clk);
        checkBit(indicatorOe, 1'b1);
        rst_n = 1'b0;
        #1;
        checkBit(indicatorOe, 1'b0);
        checkWord({16'h0000, read_config_reg}, 32'h00009CC4);
        checkBit(end_of_burst_indicator_n, 1'b1);
        checkWord(dataOut, 32'h00000000);
        @(negedge ref_clk);
        rst_n = 1'b1;
        readCheck(20'h0ABC5, arr(20'h0ABC5));
        testDone();
    end
endmodule : flash_burst_read_config_bench

`default_nettype wire
